/* sbc_irq_regs.vh */
// Register offsets, field layouts and timing constants of the interrupt status and enable block.
`ifndef SBC_IRQ_REGS_VH
`define SBC_IRQ_REGS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define ADDR_W 7
`define ADDR_SYS_EN 7'h04
`define ADDR_SUPPLY_EN 7'h1C
`define ADDR_XCVR_EN 7'h23
`define ADDR_WAKE_STAT 7'h66
`define ADDR_FAIL_STAT 7'h67

// ----------------------------------------------------------------------------
// Field layouts and reset values
// ----------------------------------------------------------------------------
`define DATA_W 8
`define REG_RESET 8'h00
`define SYS_EN_MASK 8'h06
`define SUPPLY_EN_MASK 8'h3F
`define XCVR_EN_MASK 8'h1F
`define XCVR_LIN_B_MASK 8'h08
`define SYS_SERIAL_FAIL_BIT 1
`define SYS_OVERTEMP_BIT 2
`define SUP_MAIN_UNDER_BIT 0
`define SUP_EXT_UNDER_BIT 1
`define SUP_EXT_OVER_BIT 2
`define SUP_BAT_UNDER_BIT 3
`define SUP_BAT_OVER_BIT 4
`define SUP_REGULATOR_BIT 5
`define XCVR_BUS_WAKE_BIT 0
`define XCVR_BUS_FAIL_BIT 1
`define XCVR_LIN_A_BIT 2
`define XCVR_LIN_B_BIT 3
`define XCVR_SILENCE_BIT 4
`define PIN_COUNT 4

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_MHZ 40
`define SILENCE_TO_US 1000

`endif

/* irq_flag_bank.v */
// Bank of sticky pending flags, set by hardware events and cleared by writing one.
`timescale 1ns/1ps
module irq_flag_bank #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input wire mclk,
    input wire nrst,
    // Set and clear strobes
    input wire [WIDTH-1:0] set,
    input wire [WIDTH-1:0] clr,
    // Flag state
    output wire [WIDTH-1:0] flags
);

reg [WIDTH-1:0] flags_q;
wire [WIDTH-1:0] flags_d;

// A set in the same cycle as its clear wins, so no event is lost.
assign flags_d = (flags_q & ~clr) | set;
assign flags = flags_q;

always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        flags_q <= {WIDTH{1'b0}};
    end else begin
        flags_q <= flags_d;
    end
end

endmodule // irq_flag_bank

/* bus_silence_timer.v */
// Timer that signals once when the bus has stayed silent for the timeout period.
`timescale 1ns/1ps
`include "sbc_irq_regs.vh"
module bus_silence_timer #(
    parameter CYCLES = `SILENCE_TO_US * `CLK_MHZ
) (
    // Clock and reset
    input wire mclk,
    input wire nrst,
    // Synchronised bus idle level
    input wire silent,
    // One-cycle pulse at timeout
    output wire expired
);

localparam CW = $clog2(CYCLES + 1);
localparam integer LAST_INT = CYCLES - 1;
localparam [CW-1:0] LAST = LAST_INT[CW-1:0];

reg [CW-1:0] cnt_q;
reg done_q;
reg expired_q;

assign expired = expired_q;

// Any bus activity rearms the timer; one silence period yields one pulse only.
always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        cnt_q <= {CW{1'b0}};
        done_q <= 1'b0;
        expired_q <= 1'b0;
    end else if (!silent) begin
        cnt_q <= {CW{1'b0}};
        done_q <= 1'b0;
        expired_q <= 1'b0;
    end else if (!done_q && cnt_q == LAST) begin
        done_q <= 1'b1;
        expired_q <= 1'b1;
    end else begin
        expired_q <= 1'b0;
        if (!done_q) begin
            cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
        end
    end
end

endmodule // bus_silence_timer

/* sbc_interrupt_status_enable.v */
// Interrupt pending flags and enable masks of the system basis chip.
//
// Overview of operation
// - Wake status at 66h, falling/rising per pin.
// - Fail status at 67h, short/open-load per pin.
// - Flag reads one while event pending.
// - Second-bank status absent without second bank.
// - System enable at 04h, bits 2,1.
// - Supply enable at 1Ch, bits 5..0.
// - Transceiver enable at 23h, bits 4..0.
// - Enable bit one enables, zero disables.
// - Second LIN enable reserved in single-LIN variants.
// - Regulator flag sets on status bit change.
// - Silence flag sets after silence timeout.
`timescale 1ns/1ps
`include "sbc_irq_regs.vh"
module sbc_interrupt_status_enable #(
    parameter HAS_BANK1 = 1,
    parameter HAS_LIN_B = 1,
    parameter SILENCE_TO_US = `SILENCE_TO_US,
    parameter SILENCE_CYCLES = SILENCE_TO_US * `CLK_MHZ
) (
    // Clock and reset
    input wire mclk,
    input wire nrst,
    // Register port from the serial interface
    input wire [`ADDR_W-1:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [`DATA_W-1:0] reg_wdata,
    output wire [`DATA_W-1:0] reg_rdata,
    output wire reg_rvalid,
    // Second-bank pins, index 0 is pin 5
    input wire [`PIN_COUNT-1:0] hv_pin,
    input wire [`PIN_COUNT-1:0] pin_short,
    input wire [`PIN_COUNT-1:0] pin_openload,
    input wire [`DATA_W-1:0] bank1_wake_en,
    input wire [`DATA_W-1:0] bank1_fail_en,
    // System events
    input wire overtemp_warn,
    input wire serial_fail,
    input wire [`DATA_W-1:0] sys_clr,
    output wire [`DATA_W-1:0] sys_pending,
    // Supply events
    input wire regulator_status_bit,
    input wire battery_over,
    input wire battery_under,
    input wire ext_supply_over,
    input wire ext_supply_under,
    input wire main_supply_under,
    input wire [`DATA_W-1:0] supply_clr,
    output wire [`DATA_W-1:0] supply_pending,
    // Transceiver events
    input wire bus_silent,
    input wire lin_a_wake,
    input wire lin_b_wake,
    input wire bus_failure,
    input wire bus_wake,
    input wire [`DATA_W-1:0] xcvr_clr,
    output wire [`DATA_W-1:0] xcvr_pending,
    // Interrupt indication to the microcontroller
    output wire irq
);

// ----------------------------------------------------------------------------
// Helpers
// ----------------------------------------------------------------------------
function rise;
    input cur;
    input prev;
    begin
        rise = cur & ~prev;
    end
endfunction

function is_addr;
    input [`ADDR_W-1:0] a;
    input [`ADDR_W-1:0] ref_a;
    begin
        is_addr = (a == ref_a);
    end
endfunction

localparam NSYNC = 20;
localparam [`DATA_W-1:0] XCVR_MASK = HAS_LIN_B ? `XCVR_EN_MASK
                                               : (`XCVR_EN_MASK & ~`XCVR_LIN_B_MASK);
localparam [0:0] BANK1 = HAS_BANK1 ? 1'b1 : 1'b0;

// ----------------------------------------------------------------------------
// Input synchronisers
// ----------------------------------------------------------------------------
// Every analog or pin level crosses two flops before any edge logic sees it.
reg [NSYNC-1:0] sync1_q;
reg [NSYNC-1:0] sync2_q;
reg [NSYNC-1:0] prev_q;
wire [NSYNC-1:0] async_in;

assign async_in = {bus_silent, main_supply_under, ext_supply_under, ext_supply_over,
                   battery_under, battery_over, regulator_status_bit, overtemp_warn,
                   pin_openload, pin_short, hv_pin};

always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        sync1_q <= {NSYNC{1'b0}};
        sync2_q <= {NSYNC{1'b0}};
        prev_q <= {NSYNC{1'b0}};
    end else begin
        sync1_q <= async_in;
        sync2_q <= sync1_q;
        prev_q <= sync2_q;
    end
end

wire [`PIN_COUNT-1:0] pin_s = sync2_q[3:0];
wire [`PIN_COUNT-1:0] pin_p = prev_q[3:0];
wire [`PIN_COUNT-1:0] short_s = sync2_q[7:4];
wire [`PIN_COUNT-1:0] short_p = prev_q[7:4];
wire [`PIN_COUNT-1:0] open_s = sync2_q[11:8];
wire [`PIN_COUNT-1:0] open_p = prev_q[11:8];

// ----------------------------------------------------------------------------
// Enable registers
// ----------------------------------------------------------------------------
reg [`DATA_W-1:0] sys_en_q;
reg [`DATA_W-1:0] supply_en_q;
reg [`DATA_W-1:0] xcvr_en_q;
wire wr_sys = reg_wr & is_addr(reg_addr, `ADDR_SYS_EN);
wire wr_supply = reg_wr & is_addr(reg_addr, `ADDR_SUPPLY_EN);
wire wr_xcvr = reg_wr & is_addr(reg_addr, `ADDR_XCVR_EN);
wire wr_wake = reg_wr & BANK1 & is_addr(reg_addr, `ADDR_WAKE_STAT);
wire wr_fail = reg_wr & BANK1 & is_addr(reg_addr, `ADDR_FAIL_STAT);

// Reserved bits are masked on write so they always read back as zero.
always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        sys_en_q <= `REG_RESET;
        supply_en_q <= `REG_RESET;
        xcvr_en_q <= `REG_RESET;
    end else begin
        if (wr_sys) begin
            sys_en_q <= reg_wdata & `SYS_EN_MASK;
        end
        if (wr_supply) begin
            supply_en_q <= reg_wdata & `SUPPLY_EN_MASK;
        end
        if (wr_xcvr) begin
            xcvr_en_q <= reg_wdata & XCVR_MASK;
        end
    end
end

// ----------------------------------------------------------------------------
// Event detection
// ----------------------------------------------------------------------------
reg [`DATA_W-1:0] wake_evt;
reg [`DATA_W-1:0] fail_evt;
reg [`DATA_W-1:0] sys_evt;
reg [`DATA_W-1:0] supply_evt;
reg [`DATA_W-1:0] xcvr_evt;
wire silence_expired;
integer k;

always @* begin
    wake_evt = {`DATA_W{1'b0}};
    fail_evt = {`DATA_W{1'b0}};
    sys_evt = {`DATA_W{1'b0}};
    supply_evt = {`DATA_W{1'b0}};
    xcvr_evt = {`DATA_W{1'b0}};
    for (k = 0; k < `PIN_COUNT; k = k + 1) begin
        wake_evt[2*k+1] = rise(pin_p[k], pin_s[k]);
        wake_evt[2*k] = rise(pin_s[k], pin_p[k]);
        fail_evt[2*k+1] = rise(short_s[k], short_p[k]);
        fail_evt[2*k] = rise(open_s[k], open_p[k]);
    end
    sys_evt[`SYS_OVERTEMP_BIT] = rise(sync2_q[12], prev_q[12]);
    sys_evt[`SYS_SERIAL_FAIL_BIT] = serial_fail;
    supply_evt[`SUP_REGULATOR_BIT] = sync2_q[13] ^ prev_q[13];
    supply_evt[`SUP_BAT_OVER_BIT] = rise(sync2_q[14], prev_q[14]);
    supply_evt[`SUP_BAT_UNDER_BIT] = rise(sync2_q[15], prev_q[15]);
    supply_evt[`SUP_EXT_OVER_BIT] = rise(sync2_q[16], prev_q[16]);
    supply_evt[`SUP_EXT_UNDER_BIT] = rise(sync2_q[17], prev_q[17]);
    supply_evt[`SUP_MAIN_UNDER_BIT] = rise(sync2_q[18], prev_q[18]);
    xcvr_evt[`XCVR_SILENCE_BIT] = silence_expired;
    xcvr_evt[`XCVR_LIN_B_BIT] = lin_b_wake;
    xcvr_evt[`XCVR_LIN_A_BIT] = lin_a_wake;
    xcvr_evt[`XCVR_BUS_FAIL_BIT] = bus_failure;
    xcvr_evt[`XCVR_BUS_WAKE_BIT] = bus_wake;
end

bus_silence_timer #(
    .CYCLES(SILENCE_CYCLES)
) u_silence (
    .mclk(mclk),
    .nrst(nrst),
    .silent(sync2_q[19]),
    .expired(silence_expired)
);

// ----------------------------------------------------------------------------
// Pending flags
// ----------------------------------------------------------------------------
wire [`DATA_W-1:0] wake_flags;
wire [`DATA_W-1:0] fail_flags;
wire [`DATA_W-1:0] sys_flags;
wire [`DATA_W-1:0] supply_flags;
wire [`DATA_W-1:0] xcvr_flags;
wire [`DATA_W-1:0] bank1_gate = {`DATA_W{BANK1}};

// An event is only latched while its enable is set; write-one clears.
irq_flag_bank #(.WIDTH(`DATA_W)) u_wake (
    .mclk(mclk),
    .nrst(nrst),
    .set(wake_evt & bank1_wake_en & bank1_gate),
    .clr(wr_wake ? reg_wdata : {`DATA_W{1'b0}}),
    .flags(wake_flags)
);

irq_flag_bank #(.WIDTH(`DATA_W)) u_fail (
    .mclk(mclk),
    .nrst(nrst),
    .set(fail_evt & bank1_fail_en & bank1_gate),
    .clr(wr_fail ? reg_wdata : {`DATA_W{1'b0}}),
    .flags(fail_flags)
);

irq_flag_bank #(.WIDTH(`DATA_W)) u_sys (
    .mclk(mclk),
    .nrst(nrst),
    .set(sys_evt & sys_en_q),
    .clr(sys_clr),
    .flags(sys_flags)
);

irq_flag_bank #(.WIDTH(`DATA_W)) u_supply (
    .mclk(mclk),
    .nrst(nrst),
    .set(supply_evt & supply_en_q),
    .clr(supply_clr),
    .flags(supply_flags)
);

irq_flag_bank #(.WIDTH(`DATA_W)) u_xcvr (
    .mclk(mclk),
    .nrst(nrst),
    .set(xcvr_evt & xcvr_en_q),
    .clr(xcvr_clr),
    .flags(xcvr_flags)
);

assign sys_pending = sys_flags;
assign supply_pending = supply_flags;
assign xcvr_pending = xcvr_flags;

// ----------------------------------------------------------------------------
// Interrupt indication
// ----------------------------------------------------------------------------
reg irq_q;
wire irq_d;

// Flags are masked again so a source disabled while pending stops driving the line.
assign irq_d = |(wake_flags & bank1_wake_en) | |(fail_flags & bank1_fail_en)
             | |(sys_flags & sys_en_q) | |(supply_flags & supply_en_q)
             | |(xcvr_flags & xcvr_en_q);

always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        irq_q <= 1'b0;
    end else begin
        irq_q <= irq_d;
    end
end

assign irq = irq_q;

// ----------------------------------------------------------------------------
// Read path
// ----------------------------------------------------------------------------
reg [`DATA_W-1:0] rdata_q;
reg [`DATA_W-1:0] rdata_d;
reg rvalid_q;

// Offsets that are absent in this variant read as zero like any unmapped one.
always @* begin
    rdata_d = `REG_RESET;
    case (reg_addr)
        `ADDR_SYS_EN: begin
            rdata_d = sys_en_q;
        end
        `ADDR_SUPPLY_EN: begin
            rdata_d = supply_en_q;
        end
        `ADDR_XCVR_EN: begin
            rdata_d = xcvr_en_q;
        end
        `ADDR_WAKE_STAT: begin
            rdata_d = wake_flags & bank1_gate;
        end
        `ADDR_FAIL_STAT: begin
            rdata_d = fail_flags & bank1_gate;
        end
        default: begin
            rdata_d = `REG_RESET;
        end
    endcase
end

always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        rdata_q <= `REG_RESET;
        rvalid_q <= 1'b0;
    end else begin
        rvalid_q <= reg_rd;
        if (reg_rd) begin
            rdata_q <= rdata_d;
        end
    end
end

assign reg_rdata = rdata_q;
assign reg_rvalid = rvalid_q;

endmodule // sbc_interrupt_status_enable

/* sbc_irq_chk_chk.sv */
// Port-level assertions for the interrupt status and enable block.
`timescale 1ns/1ps
module sbc_irq_chk (
    // Clock and reset
    input logic mclk,
    input logic nrst,
    // Register port
    input logic [6:0] reg_addr,
    input logic reg_wr,
    input logic reg_rd,
    input logic [7:0] reg_rdata,
    input logic reg_rvalid,
    // Flags, clears and enables
    input logic [7:0] sys_pending,
    input logic [7:0] supply_pending,
    input logic [7:0] xcvr_pending,
    input logic [7:0] supply_clr,
    input logic [7:0] xcvr_clr,
    input logic [7:0] bank1_wake_en,
    input logic [7:0] bank1_fail_en,
    // Interrupt indication
    input logic irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    sequence s_rd(logic [6:0] a);
        reg_rd && reg_addr == a;
    endsequence
    // Bits inside the mask must come back as zero with the answer.
    sequence s_answer(logic [7:0] m);
        reg_rvalid && (reg_rdata & m) == 8'h00;
    endsequence
    a_read_answer: assert property (reg_rd |=> reg_rvalid)
        else $error("read without answer");
    a_answer_cause: assert property (reg_rvalid |-> $past(reg_rd))
        else $error("answer without read");
    a_sys_reserved: assert property (s_rd(7'h04) |=> s_answer(8'hf9))
        else $error("system enable reserved bits set");
    a_supply_reserved: assert property (s_rd(7'h1c) |=> s_answer(8'hc0))
        else $error("supply enable reserved bits set");
    a_xcvr_reserved: assert property (s_rd(7'h23) |=> s_answer(8'he0))
        else $error("transceiver enable reserved bits set");
    a_unmapped_zero: assert property (reg_rd && !(reg_addr inside
        {7'h04, 7'h1c, 7'h23, 7'h66, 7'h67}) |=> s_answer(8'hff))
        else $error("unmapped read not zero");
    a_supply_sticky: assert property ((($past(supply_pending) &
        ~$past(supply_clr)) & ~supply_pending) == 8'h00)
        else $error("supply flag lost without clear");
    a_xcvr_sticky: assert property ((($past(xcvr_pending) &
        ~$past(xcvr_clr)) & ~xcvr_pending) == 8'h00)
        else $error("transceiver flag lost without clear");
    a_irq_rise: assert property ($rose(|xcvr_pending) && !$past(reg_wr) |=> irq)
        else $error("irq missing after flag");
    a_irq_quiet: assert property (sys_pending == 8'h00 &&
        supply_pending == 8'h00 && xcvr_pending == 8'h00 &&
        bank1_wake_en == 8'h00 && bank1_fail_en == 8'h00 |=> !irq)
        else $error("irq without pending flag");
endmodule // sbc_irq_chk

/* sbc_host_model.sv */
// Microcontroller model reaching the registers through the strobe port.
`timescale 1ns/1ps
module sbc_host_model (
    // Clock
    input logic mclk,
    // Register strobe port
    output logic [6:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata,
    input logic [7:0] reg_rdata,
    input logic reg_rvalid
);
    initial begin
        reg_addr = 7'h7f;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        reg_wdata = 8'h00;
    end
    // Writing one clears a flag, zero leaves it alone.
    // Idle address and data are inverted so stale values are never reused.
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'h1;
        @(posedge mclk);
        #1;
        reg_wr = 1'h0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic ok);
        @(posedge mclk);
        #1;
        reg_addr = a;
        reg_rd = 1'h1;
        @(posedge mclk);
        #1;
        reg_rd = 1'h0;
        reg_addr = ~a;
        ok = reg_rvalid;
        d = reg_rdata;
    endtask
endmodule // sbc_host_model

/* tb_sbc_interrupt_status_enable.sv */
// Self-checking testbench of the interrupt status and enable block.
`timescale 1ns/1ps
module tb_sbc_interrupt_status_enable;
    logic mclk = 1'h0;
    logic nrst = 1'h0;
    logic [6:0] reg_addr;
    logic reg_wr, reg_rd, reg_rvalid, irq, ok;
    logic [7:0] reg_wdata, reg_rdata, sys_pending, supply_pending, xcvr_pending, rv;
    logic [3:0] hv_pin = 4'h0, pin_short = 4'h0, pin_openload = 4'h0;
    logic [7:0] bank1_wake_en = 8'h00, bank1_fail_en = 8'h00;
    logic [7:0] sys_clr = 8'h00, supply_clr = 8'h00, xcvr_clr = 8'h00;
    logic overtemp_warn = 1'h0, serial_fail = 1'h0, bus_silent = 1'h0;
    logic regulator_status_bit, battery_over, battery_under;
    logic ext_supply_over, ext_supply_under, main_supply_under;
    logic lin_a_wake, lin_b_wake, bus_failure, bus_wake;
    logic [7:0] lite_rdata, lite_xcvr;
    logic lite_irq;
    logic [5:0] sup_ev = 6'h00;
    logic [3:0] xc_ev = 4'h0;
    int failures = 0;
    int checks_done = 0;
    assign {regulator_status_bit, battery_over, battery_under, ext_supply_over,
        ext_supply_under, main_supply_under} = sup_ev;
    assign {lin_b_wake, lin_a_wake, bus_failure, bus_wake} = xc_ev;
    always #12.5 mclk = ~mclk;
    // Silence timeout shortened so the run stays brief.
    sbc_interrupt_status_enable #(.SILENCE_CYCLES(8)) sbc_interrupt_status_enable_i (
        .mclk, .nrst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .reg_rvalid, .hv_pin, .pin_short, .pin_openload, .bank1_wake_en,
        .bank1_fail_en, .overtemp_warn, .serial_fail, .sys_clr, .sys_pending,
        .regulator_status_bit, .battery_over, .battery_under, .ext_supply_over,
        .ext_supply_under, .main_supply_under, .supply_clr, .supply_pending,
        .bus_silent, .lin_a_wake, .lin_b_wake, .bus_failure, .bus_wake,
        .xcvr_clr, .xcvr_pending, .irq);
    // Variant without the second bank and with one LIN channel; it shares every input.
    sbc_interrupt_status_enable #(.HAS_BANK1(0), .HAS_LIN_B(0), .SILENCE_CYCLES(8))
        sbc_interrupt_status_enable_lite_i (
        .mclk, .nrst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata(lite_rdata),
        .reg_rvalid(), .hv_pin, .pin_short, .pin_openload, .bank1_wake_en,
        .bank1_fail_en, .overtemp_warn, .serial_fail, .sys_clr, .sys_pending(),
        .regulator_status_bit, .battery_over, .battery_under, .ext_supply_over,
        .ext_supply_under, .main_supply_under, .supply_clr, .supply_pending(),
        .bus_silent, .lin_a_wake, .lin_b_wake, .bus_failure, .bus_wake,
        .xcvr_clr, .xcvr_pending(lite_xcvr), .irq(lite_irq));
    sbc_host_model sbc_host_model_i (.mclk, .reg_addr, .reg_wr, .reg_rd,
        .reg_wdata, .reg_rdata, .reg_rvalid);
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", n, e, g);
            failures++;
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
        sbc_host_model_i.rd(a, rv, ok);
        chk("reg_rvalid", 8'h01, {7'h00, ok});
        chk("reg_rdata", e, rv);
    endtask
    task automatic final_report;
        if (failures == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic t_reset_and_enables;
        chk("irq", 8'h00, {7'h00, irq});
        rdchk(7'h66, 8'h00);
        rdchk(7'h67, 8'h00);
        sup_ev[4] = 1'h1;
        tick(5);
        chk("supply_pending", 8'h00, supply_pending);
        sup_ev[4] = 1'h0;
        tick(4);
        sbc_host_model_i.wr(7'h04, 8'hff);
        sbc_host_model_i.wr(7'h1c, 8'hff);
        sbc_host_model_i.wr(7'h23, 8'hff);
        sbc_host_model_i.wr(7'h10, 8'hff);
        rdchk(7'h04, 8'h06);
        rdchk(7'h1c, 8'h3f);
        rdchk(7'h23, 8'h1f);
        chk("lite reg_rdata", 8'h17, lite_rdata);
        rdchk(7'h10, 8'h00);
        chk("supply_pending", 8'h00, supply_pending);
    endtask
    task automatic t_sys;
        serial_fail = 1'h1;
        tick(1);
        serial_fail = 1'h0;
        tick(1);
        chk("sys_pending", 8'h02, sys_pending);
        chk("irq", 8'h01, {7'h00, irq});
        overtemp_warn = 1'h1;
        tick(4);
        chk("sys_pending", 8'h06, sys_pending);
        sys_clr = 8'h06;
        tick(1);
        sys_clr = 8'h00;
        tick(1);
        chk("sys_pending", 8'h00, sys_pending);
    endtask
    task automatic t_supply;
        for (int i = 0; i < 6; i++) begin
            sup_ev[i] = 1'h1;
            tick(4);
            chk("supply_pending", (8'h02 << i) - 8'h01, supply_pending);
        end
        supply_clr = 8'h3f;
        tick(1);
        supply_clr = 8'h00;
        sup_ev[5] = 1'h0;
        tick(4);
        chk("supply_pending", 8'h20, supply_pending);
        supply_clr = 8'h20;
        tick(1);
        supply_clr = 8'h00;
        tick(1);
        chk("irq", 8'h00, {7'h00, irq});
    endtask
    task automatic t_xcvr;
        int n;
        for (int i = 0; i < 4; i++) begin
            xc_ev[i] = 1'h1;
            tick(1);
            xc_ev[i] = 1'h0;
            chk("xcvr_pending", (8'h02 << i) - 8'h01, xcvr_pending);
        end
        chk("lite xcvr_pending", 8'h07, lite_xcvr);
        xcvr_clr = 8'h1f;
        tick(1);
        xcvr_clr = 8'h00;
        bus_silent = 1'h1;
        n = 0;
        while (xcvr_pending[4] !== 1'h1 && n < 40) begin
            tick(1);
            n++;
        end
        chk("silence_wait", 8'h01, {7'h00, n >= 8 && n < 40});
        if (n >= 40) final_report;
        xcvr_clr = 8'h10;
        tick(1);
        xcvr_clr = 8'h00;
        tick(20);
        chk("xcvr_pending", 8'h00, xcvr_pending);
        bus_silent = 1'h0;
    endtask
    task automatic t_bank1;
        bank1_wake_en = 8'hff;
        bank1_fail_en = 8'hff;
        hv_pin = 4'h1;
        tick(4);
        hv_pin = 4'h0;
        tick(4);
        hv_pin = 4'h8;
        pin_short = 4'h2;
        pin_openload = 4'h4;
        tick(4);
        rdchk(7'h66, 8'h43);
        chk("lite reg_rdata", 8'h00, lite_rdata);
        rdchk(7'h67, 8'h18);
        chk("lite reg_rdata", 8'h00, lite_rdata);
        chk("irq", 8'h01, {7'h00, irq});
        chk("lite irq", 8'h00, {7'h00, lite_irq});
        sbc_host_model_i.wr(7'h66, 8'h01);
        rdchk(7'h66, 8'h42);
        sbc_host_model_i.wr(7'h66, 8'h42);
        sbc_host_model_i.wr(7'h67, 8'h18);
        tick(1);
        chk("irq", 8'h00, {7'h00, irq});
        rdchk(7'h67, 8'h00);
    endtask
    initial begin
        repeat (6) @(posedge mclk);
        #1;
        nrst = 1'h1;
        t_reset_and_enables;
        t_sys;
        t_supply;
        t_xcvr;
        t_bank1;
        final_report;
    end
endmodule // tb_sbc_interrupt_status_enable

bind sbc_interrupt_status_enable sbc_irq_chk sbc_irq_chk_i (.mclk, .nrst, .reg_addr,
    .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid, .sys_pending, .supply_pending,
    .xcvr_pending, .supply_clr, .xcvr_clr, .bank1_wake_en, .bank1_fail_en, .irq);
